// >>> rtl/axil_reg_slave.sv
// axi4-lite slave front end with one write and one read in flight
`include "console_switch_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module axil_reg_slave (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic wrEn,
    output logic [7:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    input wire logic wrOk,
    input wire logic [31:0] rdData,
    input wire logic rdOk
);
    typedef struct packed {
        logic awHeld;
        logic wHeld;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } axil_state_type;
    axil_state_type st;
    axil_state_type next_st;

    // address and data are held apart so either may come first
    assign awready = !st.awHeld && !st.bv;
    assign wready = !st.wHeld && !st.bv;
    assign arready = !st.rv;
    assign wrEn = st.awHeld && st.wHeld && !st.bv;
    assign wrAddr = st.addr;
    assign wrData = st.data;
    assign wrStrb = st.strb;

    always_comb
    begin
        next_st = st;
        if (awvalid && awready)
        begin
            next_st.awHeld = 1'b1;
            next_st.addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_st.wHeld = 1'b1;
            next_st.data = wdata;
            next_st.strb = wstrb;
        end
        if (wrEn)
        begin
            next_st.awHeld = 1'b0;
            next_st.wHeld = 1'b0;
            next_st.bv = 1'b1;
            next_st.br = wrOk ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
        end
        if (st.bv && bready)
            next_st.bv = 1'b0;
        // read data is captured on the address edge, one cycle latency
        if (arvalid && arready)
        begin
            next_st.rv = 1'b1;
            next_st.rd = rdData;
            next_st.rr = rdOk ? `CSC_RESP_OKAY : `CSC_RESP_SLVERR;
        end
        else if (st.rv && rready)
        begin
            next_st.rv = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            st <= '0;
        else
            st <= next_st;
    end

    assign bvalid = st.bv;
    assign bresp = st.br;
    assign rvalid = st.rv;
    assign rdata = st.rd;
    assign rresp = st.rr;
endmodule // axil_reg_slave
`default_nettype wire

// >>> rtl/console_switch_consts.svh
// constants for the console switch control block
`ifndef CONSOLE_SWITCH_CONSTS_SVH
`define CONSOLE_SWITCH_CONSTS_SVH
`define CSC_CLK_NS 20
`define CSC_RESYNC_NS 320
`define CSC_RESYNC_CYCLES ((`CSC_RESYNC_NS + `CSC_CLK_NS - 1) / `CSC_CLK_NS)
`define CSC_ADDR_MODE 8'h00
`define CSC_ADDR_STATUS 8'h04
`define CSC_ADDR_STOPIND 8'h08
`define CSC_RESP_OKAY 2'h0
`define CSC_RESP_SLVERR 2'h2
`define CSC_SW_W 15
`endif

// >>> rtl/console_switch_control.sv
// operating-control logic between console switches and machine sequencing
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`include "console_switch_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module console_switch_control
    import console_switch_pkg::*;
#(
    parameter int RESYNC_CYCLES = `CSC_RESYNC_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    // console lever switches, asynchronous
    input wire logic decDisconnectUp,
    input wire logic advDisconnectUp,
    input wire logic lowSpeedOsc,
    input wire logic traceSwOn,
    input wire logic [2:0] selJumpSwOn,
    input wire logic [2:0] selStopSwOn,
    input wire logic loadSwNormal,
    input wire logic tape_load_mode,
    input wire logic stepSwDown,
    input wire logic runSwUp,
    input wire logic commandModeSw,
    // machine side, same clock
    input wire logic decRequest,
    input wire logic [2:0] advRequest,
    input wire logic mainFault,
    input wire logic traceJumpEnd,
    input wire logic traceFlagTaken,
    input wire logic selStopExec,
    input wire logic [2:0] stopModifier,
    input wire logic readNextEnable,
    input wire logic commandStepPoint,
    // outputs
    output logic decStrobe,
    output logic advStrobe,
    output logic oscPulse,
    output logic traceLamp,
    output logic traceFlag,
    output logic traceDecodeEn,
    output logic [2:0] selJumpFlag,
    output logic [2:0] selStopFlag,
    output logic [2:0] selective_halt_one_lamp,
    output logic stopPulse,
    output logic fault_lamp,
    output logic faultPanelLamp,
    output logic masterClear,
    output logic clearQLoad,
    output logic tapeLoad,
    output logic stepPulse,
    output logic runPulse,
    output logic commandSeqActive,
    output logic highSpeedMode,
    output logic instrStepMode,
    output logic cmdStepMode,
    // axi4-lite register port
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    typedef struct packed {
        logic [15:0] rsCount;
        logic oscSync;
        logic oscArm;
        logic oscPulse;
        logic traceStage;
        logic traceEn;
        logic traceEnLast;
        logic traceFlag;
        logic [2:0] sjStage;
        logic [2:0] sjFlag;
        logic [2:0] ssStage;
        logic [2:0] ssFlag;
        logic [2:0] stopInd;
        logic stopPulse;
        logic normStage;
        logic loadArm;
        logic tapeStage;
        logic tapeLoad;
        logic clearQ;
        logic mcPulse;
        logic stepRs;
        logic runRs;
        logic commonRs;
        logic stepPulse;
        logic runPulse;
        cmd_state_type cmdState;
        logic highSpeed;
        logic instrStep;
        logic cmdStep;
        logic fault;
        logic decStrobe;
        logic advStrobe;
    } ctl_state_type;
    ctl_state_type st;
    ctl_state_type next_st;

    logic [`CSC_SW_W-1:0] swRaw;
    logic [`CSC_SW_W-1:0] sw;
    logic rsPulse;
    logic fireLoadClear;
    logic fireLoadExit;
    logic fireStep;
    logic fireRun;
    logic modeClear;
    logic wrEn;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic wrOk;
    logic [31:0] rdData;
    logic rdOk;

    // one switch stage sampled on a resync pulse, held between pulses
    function automatic logic resyncStage(input logic rs, input logic swOn, input logic hold);
        resyncStage = rs ? swOn : hold;
    endfunction

    function automatic logic regHit(input logic [7:0] a);
        regHit = (a == `CSC_ADDR_MODE) || (a == `CSC_ADDR_STATUS) || (a == `CSC_ADDR_STOPIND);
    endfunction

    assign swRaw = {commandModeSw, runSwUp, stepSwDown, tape_load_mode,
        loadSwNormal, selStopSwOn, selJumpSwOn, traceSwOn, lowSpeedOsc,
        advDisconnectUp, decDisconnectUp};

    // switches are asynchronous: all pass the three-stage filter
    pin_sync #(.W(`CSC_SW_W)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pinIn(swRaw),
        .pinOut(sw)
    );

    axil_reg_slave u_bus (
        .clk_sys(clk_sys),
        .reset(reset),
        .awvalid(awvalid),
        .awready(awready),
        .awaddr(awaddr),
        .wvalid(wvalid),
        .wready(wready),
        .wdata(wdata),
        .wstrb(wstrb),
        .bvalid(bvalid),
        .bready(bready),
        .bresp(bresp),
        .arvalid(arvalid),
        .arready(arready),
        .araddr(araddr),
        .rvalid(rvalid),
        .rready(rready),
        .rdata(rdata),
        .rresp(rresp),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .wrOk(wrOk),
        .rdData(rdData),
        .rdOk(rdOk)
    );

    // resync pulse marks the instants the lever stages sample; disconnect, oscillator and command-mode switches are also read between pulses
    assign rsPulse = (st.rsCount == 16'h0000);
    assign fireLoadClear = rsPulse && st.loadArm && st.tapeStage;
    assign fireLoadExit = rsPulse && st.tapeLoad && st.normStage;
    assign fireStep = rsPulse && st.stepRs && st.commonRs;
    assign fireRun = rsPulse && st.runRs && st.commonRs;
    // halting sources: fault, stop at read-next, leaving tape load
    assign modeClear = st.fault || (st.stopPulse && readNextEnable)
        || fireLoadExit;
    assign wrOk = regHit(wrAddr);
    assign rdOk = regHit(araddr);

    // read mux; unmapped addresses read zero with an error response
    always_comb
    begin
        rdData = 32'h00000000;
        case (araddr)
            `CSC_ADDR_MODE:
                rdData[2:0] = {st.cmdStep, st.instrStep, st.highSpeed};
            `CSC_ADDR_STATUS:
                rdData[15:0] = {st.cmdState == CMD_RUN, st.tapeLoad, st.clearQ,
                    st.traceEn, st.traceFlag, st.stopInd, st.ssFlag, st.sjFlag,
                    st.fault, st.oscSync};
            `CSC_ADDR_STOPIND:
                rdData[2:0] = st.stopInd;
            default:
                rdData = 32'h00000000;
        endcase
    end

    always_comb
    begin
        next_st = st;
        next_st.rsCount = rsPulse ? 16'(RESYNC_CYCLES - 1) : st.rsCount - 16'h0001;
        next_st.oscPulse = 1'b0;
        next_st.stopPulse = 1'b0;
        next_st.mcPulse = 1'b0;
        next_st.stepPulse = 1'b0;
        next_st.runPulse = 1'b0;
        // disconnect switches gate the strobes before they are issued
        next_st.decStrobe = decRequest && !sw[0];
        next_st.advStrobe = (|advRequest) && !sw[1];
        // low-speed oscillator: sync flag follows positive phase
        if (!sw[2])
            next_st.oscSync = 1'b0;
        else if (rsPulse)
            next_st.oscSync = 1'b1;
        if (!st.oscSync)
            next_st.oscArm = 1'b1;
        else if (rsPulse && st.oscArm)
        begin
            next_st.oscArm = 1'b0;
            next_st.oscPulse = 1'b1;
        end
        // trace: two stages, both cleared at a pulse once released
        next_st.traceStage = resyncStage(rsPulse, sw[3], st.traceStage);
        next_st.traceEn = resyncStage(rsPulse, sw[3] && st.traceStage,
            st.traceEn);
        next_st.traceEnLast = st.traceEn;
        if (traceFlagTaken)
            next_st.traceFlag = 1'b0;
        // set wins over the machine taking the flag
        if (st.traceEn && !st.traceEnLast)
            next_st.traceFlag = 1'b1;
        if (st.traceEn && traceJumpEnd)
            next_st.traceFlag = 1'b1;
        // indicate flags: software clear by writing ones, hardware set below wins
        if (wrEn && wrAddr == `CSC_ADDR_STOPIND && wrStrb[0])
            next_st.stopInd = st.stopInd & ~wrData[2:0];
        // selective jump and stop switches, three of each
        for (int i = 0; i < 3; i++)
        begin
            next_st.sjStage[i] = resyncStage(rsPulse, sw[4+i], st.sjStage[i]);
            next_st.sjFlag[i] = resyncStage(rsPulse, sw[4+i] && st.sjStage[i],
                st.sjFlag[i]);
            next_st.ssStage[i] = resyncStage(rsPulse, sw[7+i], st.ssStage[i]);
            next_st.ssFlag[i] = resyncStage(rsPulse, sw[7+i] && st.ssStage[i],
                st.ssFlag[i]);
            // modifier m and m+4 both select stop i+1
            if (selStopExec && stopModifier[1:0] == 2'(i + 1) && st.ssFlag[i])
            begin
                next_st.stopPulse = 1'b1;
                next_st.stopInd[i] = 1'b1;
            end
        end
        // load switch: normal arms the clear, tape enables tape input
        next_st.normStage = resyncStage(rsPulse, sw[10], st.normStage);
        if (fireLoadClear)
        begin
            next_st.loadArm = 1'b0;
            next_st.mcPulse = 1'b1;
            next_st.clearQ = 1'b1;
        end
        else if (rsPulse && sw[10] && st.normStage)
        begin
            next_st.loadArm = 1'b1;
        end
        next_st.tapeStage = resyncStage(rsPulse, sw[11], st.tapeStage);
        if (fireLoadExit)
        begin
            next_st.tapeLoad = 1'b0;
            next_st.clearQ = 1'b0;
        end
        else if (rsPulse && sw[11] && st.tapeStage)
        begin
            next_st.tapeLoad = 1'b1;
        end
        // run/step lever: normal arms, a lever position fires once
        next_st.stepRs = resyncStage(rsPulse, sw[12], st.stepRs);
        next_st.runRs = resyncStage(rsPulse, sw[13], st.runRs);
        if (fireStep || fireRun)
            next_st.commonRs = 1'b0;
        else if (rsPulse && !sw[12] && !sw[13])
            next_st.commonRs = 1'b1;
        next_st.stepPulse = fireStep && !st.fault;
        next_st.runPulse = fireRun && !st.fault;
        // command-step sequence runs to the next step point, then waits
        case (st.cmdState)
            CMD_IDLE:
                if (st.stepPulse && sw[14])
                    next_st.cmdState = CMD_RUN;
            CMD_RUN:
                if (commandStepPoint)
                    next_st.cmdState = CMD_IDLE;
            default:
                next_st.cmdState = CMD_IDLE;
        endcase
        // fault level straight from the machine, lights both lamps
        next_st.fault = mainFault;
        // software selects modes; any halting source wins over a write
        if (wrEn && wrAddr == `CSC_ADDR_MODE && wrStrb[0])
        begin
            next_st.highSpeed = wrData[0];
            next_st.instrStep = wrData[1];
            next_st.cmdStep = wrData[2];
        end
        if (modeClear)
        begin
            next_st.highSpeed = 1'b0;
            next_st.instrStep = 1'b0;
            next_st.cmdStep = 1'b0;
        end
    end

    // reset zeroes every stage, flag and mode register
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            st <= '0;
        else
            st <= next_st;
    end

    assign decStrobe = st.decStrobe;
    assign advStrobe = st.advStrobe;
    assign oscPulse = st.oscPulse;
    assign traceLamp = st.traceEn;
    assign traceFlag = st.traceFlag;
    assign traceDecodeEn = st.traceEn;
    assign selJumpFlag = st.sjFlag;
    assign selStopFlag = st.ssFlag;
    assign selective_halt_one_lamp = st.stopInd;
    assign stopPulse = st.stopPulse;
    assign fault_lamp = st.fault;
    assign faultPanelLamp = st.fault;
    assign masterClear = st.mcPulse;
    assign clearQLoad = st.clearQ;
    assign tapeLoad = st.tapeLoad;
    assign stepPulse = st.stepPulse;
    assign runPulse = st.runPulse;
    assign commandSeqActive = (st.cmdState == CMD_RUN);
    assign highSpeedMode = st.highSpeed;
    assign instrStepMode = st.instrStep;
    assign cmdStepMode = st.cmdStep;

    a_dec_blocked: assert property (@(posedge clk_sys) disable iff (reset)
        $past(sw[0]) |-> !decStrobe)
        else $error("decrement strobe while disconnected");
    a_adv_blocked: assert property (@(posedge clk_sys) disable iff (reset)
        $past(sw[1]) |-> !advStrobe)
        else $error("advance strobe while disconnected");
    a_osc_single: assert property (@(posedge clk_sys) disable iff (reset)
        oscPulse ##1 st.oscSync [*4] |-> !oscPulse)
        else $error("oscillator pulse repeated");
    a_osc_needs_sync: assert property (@(posedge clk_sys) disable iff (reset)
        oscPulse |-> $past(st.oscSync) && $past(rsPulse) && !st.oscArm)
        else $error("oscillator pulse without sync flag");
    a_trace_rise: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(traceDecodeEn) |=> traceFlag)
        else $error("trace flag not set when trace enabled");
    a_trace_jump: assert property (@(posedge clk_sys) disable iff (reset)
        st.traceEn && traceJumpEnd |=> traceFlag)
        else $error("trace flag not set after trace jump");
    a_fault_stop: assert property (@(posedge clk_sys) disable iff (reset)
        fault_lamp |=> !stepPulse && !runPulse && !highSpeedMode && !cmdStepMode)
        else $error("fault did not block step or clear modes");
    a_stop_halt: assert property (@(posedge clk_sys) disable iff (reset)
        stopPulse && readNextEnable |=> !highSpeedMode && !instrStepMode && !cmdStepMode)
        else $error("stop with read-next did not halt");
    a_load_clear: assert property (@(posedge clk_sys) disable iff (reset)
        fireLoadClear |=> masterClear && clearQLoad ##1 !masterClear)
        else $error("tape load master clear not a single pulse");
    a_cmd_wait: assert property (@(posedge clk_sys) disable iff (reset)
        commandSeqActive && commandStepPoint |=> !commandSeqActive)
        else $error("command step did not halt at step point");
endmodule // console_switch_control
`default_nettype wire

// >>> rtl/console_switch_pkg.sv
// types shared by the console switch control block
package console_switch_pkg;
    typedef enum logic [0:0] {
        CMD_IDLE = 1'b0,
        CMD_RUN = 1'b1
    } cmd_state_type;
endpackage

// >>> rtl/pin_sync.sv
// three-stage synchroniser with agreement filter for console pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_type;
    sync_state_type st;
    sync_state_type next_st;

    // a bit changes only once stages two and three agree
    always_comb
    begin
        next_st = st;
        next_st.s1 = pinIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st.s2[i] == st.s3[i])
            begin
                next_st.q[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            st <= '0;
        else
            st <= next_st;
    end

    assign pinOut = st.q;
endmodule // pin_sync
`default_nettype wire

// >>> verification/console_panel.sv
// lever switch panel model: registered switch levels as the operator sets them
`timescale 1ns/1ps
`default_nettype none
module console_panel (
    input wire logic clk_sys,
    input wire logic [14:0] want,
    output var logic decDisconnectUp,
    output var logic advDisconnectUp,
    output var logic lowSpeedOsc,
    output var logic traceSwOn,
    output var logic [2:0] selJumpSwOn,
    output var logic [2:0] selStopSwOn,
    output var logic loadSwNormal,
    output var logic tape_load_mode,
    output var logic stepSwDown,
    output var logic runSwUp,
    output var logic commandModeSw
);
    // levers move only after an edge; the load lever cannot sit in two places
    always_ff @(posedge clk_sys)
    begin
        {decDisconnectUp, advDisconnectUp, lowSpeedOsc, traceSwOn, selJumpSwOn} <= want[14:8];
        {selStopSwOn, loadSwNormal, stepSwDown, runSwUp, commandModeSw} <= {want[7:4], want[2:0]};
        tape_load_mode <= want[3] & ~want[4];
    end
endmodule // console_panel
`default_nettype wire

// >>> verification/console_switch_control_tb.sv
// self-checking bench for the console switch control block
`timescale 1ns/1ps
`default_nettype none
module console_switch_control_tb;
    logic clk_sys = 0, reset = 1, decDisconnectUp, advDisconnectUp, lowSpeedOsc, traceSwOn;
    logic loadSwNormal, tape_load_mode, stepSwDown, runSwUp, commandModeSw;
    logic [2:0] selJumpSwOn, selStopSwOn, advRequest = 0, stopModifier = 0;
    logic [14:0] want = 15'h0010;
    logic decRequest = 0, mainFault = 0, traceJumpEnd = 0, traceFlagTaken = 0, selStopExec = 0;
    logic readNextEnable = 0, commandStepPoint = 0, decStrobe, advStrobe, oscPulse, traceLamp;
    logic traceFlag, traceDecodeEn, stopPulse, fault_lamp, faultPanelLamp, masterClear;
    logic clearQLoad, tapeLoad, stepPulse, runPulse, commandSeqActive;
    logic highSpeedMode, instrStepMode, cmdStepMode;
    logic [2:0] selJumpFlag, selStopFlag, selective_halt_one_lamp;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0, arvalid = 0, arready;
    logic rvalid, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    int err_count = 0, checked = 0, cyc = 0, oscCnt = 0, stopCnt = 0;
    int mcCnt = 0, stepCnt = 0, runCnt = 0;
    console_panel console_panel_inst (.*);
    console_switch_control #(.RESYNC_CYCLES(4)) console_switch_control_inst (.*);
    always #10 clk_sys = ~clk_sys;
    // pulses are counted here so no one-cycle event slips past a scenario
    always @(posedge clk_sys)
    begin
        cyc++;
        oscCnt += oscPulse;
        stopCnt += stopPulse;
        mcCnt += masterClear;
        stepCnt += stepPulse;
        runCnt += runPulse;
        if (cyc == 4000)
        begin
            err_count++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        // the two halves may be taken on different edges
        fork
            begin @(posedge clk_sys iff awready); awvalid <= 0; end
            begin @(posedge clk_sys iff wready); wvalid <= 0; end
        join
        @(posedge clk_sys iff bvalid);
        bready <= 0;
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        @(posedge clk_sys iff arready);
        arvalid <= 0;
        @(posedge clk_sys iff rvalid);
        rready <= 0;
        d = rdata;
        r = rresp;
    endtask
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // one-cycle machine pulse; registered outputs have settled on return
    task automatic strobe(input int k);
        traceFlagTaken <= (k == 0);
        traceJumpEnd <= (k == 1);
        commandStepPoint <= (k == 2);
        waitc(1);
        {traceFlagTaken, traceJumpEnd, commandStepPoint} <= 3'h0;
        waitc(2);
    endtask
    task automatic t_disc();
        decRequest <= 1;
        advRequest <= 3'h4;
        waitc(20);
        chk("decStrobe", 1, decStrobe);
        chk("advStrobe", 1, advStrobe);
        want[14:13] <= 2'h3;
        waitc(20);
        chk("decStrobe", 0, decStrobe);
        chk("advStrobe", 0, advStrobe);
        $display("disconnect done");
    endtask
    task automatic t_osc();
        want[12] <= 1;
        waitc(40);
        want[12] <= 0;
        waitc(30);
        want[12] <= 1;
        waitc(40);
        chk("oscPulse count", 2, oscCnt);
        $display("oscillator done");
    endtask
    task automatic t_sel();
        want[10:5] <= 6'h2a;
        wr(8'h00, 32'h7);
        waitc(20);
        chk("selJumpFlag", 5, selJumpFlag);
        chk("selStopFlag", 2, selStopFlag);
        stopModifier <= 3'h6;
        readNextEnable <= 1;
        selStopExec <= 1;
        @(posedge clk_sys);
        selStopExec <= 0;
        waitc(4);
        chk("stopLamp", 2, selective_halt_one_lamp);
        chk("stopPulse count", 1, stopCnt);
        chk("highSpeedMode", 0, highSpeedMode);
        rd(8'h04);
        chk("status", 32'h00000255, d);
        wr(8'h08, 32'h2);
        chk("bresp", 0, r);
        chk("stopLamp", 0, selective_halt_one_lamp);
        $display("selective done");
    endtask
    task automatic t_fault();
        rd(8'h00);
        chk("mode reset", 0, d);
        wr(8'h00, 32'h7);
        rd(8'h00);
        chk("mode", 7, d);
        mainFault <= 1;
        waitc(4);
        chk("fault_lamp", 1, fault_lamp);
        chk("faultPanelLamp", 1, faultPanelLamp);
        chk("cmdStepMode", 0, cmdStepMode);
        rd(8'h0c);
        chk("unmapped resp", 2, r);
        $display("fault done");
    endtask
    task automatic t_trace();
        want[11] <= 1;
        waitc(25);
        chk("traceLamp", 1, traceLamp);
        chk("traceDecodeEn", 1, traceDecodeEn);
        chk("traceFlag", 1, traceFlag);
        strobe(0);
        chk("traceFlag", 0, traceFlag);
        strobe(1);
        chk("traceFlag", 1, traceFlag);
        strobe(0);
        want[11] <= 0;
        waitc(25);
        strobe(1);
        chk("traceLamp", 0, traceLamp);
        chk("traceFlag", 0, traceFlag);
        $display("trace done");
    endtask
    task automatic t_load();
        want[4:3] <= 2'h1;
        waitc(30);
        chk("tapeLoad", 1, tapeLoad);
        chk("clearQLoad", 1, clearQLoad);
        chk("masterClear count", 1, mcCnt);
        wr(8'h00, 32'h7);
        chk("highSpeedMode", 1, highSpeedMode);
        want[4:3] <= 2'h2;
        waitc(30);
        chk("tapeLoad", 0, tapeLoad);
        chk("instrStepMode", 0, instrStepMode);
        chk("masterClear count", 1, mcCnt);
        $display("tape load done");
    endtask
    task automatic t_step();
        want[2:0] <= 3'h5;
        waitc(30);
        chk("stepPulse count", 1, stepCnt);
        chk("commandSeqActive", 1, commandSeqActive);
        strobe(2);
        chk("commandSeqActive", 0, commandSeqActive);
        want[2:0] <= 3'h1;
        waitc(20);
        want[2:0] <= 3'h3;
        waitc(30);
        chk("runPulse count", 1, runCnt);
        want[2:0] <= 3'h1;
        mainFault <= 1;
        waitc(20);
        want[2:0] <= 3'h5;
        waitc(30);
        chk("stepPulse count", 1, stepCnt);
        mainFault <= 0;
        want[2:0] <= 3'h1;
        $display("step done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        waitc(20);
        reset <= 0;
        waitc(2);
        t_fault();
        mainFault <= 0;
        t_disc();
        t_osc();
        t_sel();
        t_trace();
        t_load();
        t_step();
        final_report();
    end
endmodule // console_switch_control_tb
`default_nettype wire
